// ===== design/pwm_unit.sv
// Three generator pulse width unit with output control, fault override and APB registers
//
// Contract
// R01: There are three independent generators and one shared output stage feeding all pins.
// R02: Each generator has a 16-bit counter, down-only or up/down, and two comparators on it.
// R03: Each generator makes two outputs, independent or a linked pair with dead band.
// R04: Each generator has its own interrupt output and a separate trigger output.
// R05: The output stage inverts each output as configured and gates each one to its pin.
// R06: Outputs 0/1 come from generator 0, 2/3 from 1, 4/5 from 2, even output first.
// R07: Software uses comparator A only for the even output and B only for the odd one.
// R08: With dead band off the second output follows comparator B with no coupling.
// R09: With dead band on, rising and falling edges are delayed by their own tick counts.
// R10: With dead band on the second output is derived from the first, giving a complement.
// R11: Writing a one to the fault status bit clears only that bit.
// R12: Down mode counts from the period value to zero and then reloads it.
// R13: Up/down mode counts zero to period and back to zero, repeating.
// R14: Period and compare updates apply only at counter zero, and in sync mode after a sync.
// R15: A disabled generator holds its counter.
// R16: While a fault is active each selected output is forced to its configured safe level.
`timescale 1ns/1ps
`default_nettype none
module pwm_unit
	import pwm_unit_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pwm_unit_pkg::ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic faultPin,
	output logic wave_out_0,
	output logic wave_out_1,
	output logic wave_out_2,
	output logic wave_out_3,
	output logic wave_out_4,
	output logic wave_out_5,
	output logic [pwm_unit_pkg::GEN_COUNT-1:0] genIrq,
	output logic [pwm_unit_pkg::GEN_COUNT-1:0] genTrigger,
	output logic irq
);
	import pwm_unit_pkg::*;

	// Register file
	logic [5:0] outEnable, invert, faultSelect, faultLevel;
	logic [31:0] intStatus;
	logic [31:0] intMask;
	genCtrl_s genCtrl [GEN_COUNT];
	genTiming_s shadowTiming [GEN_COUNT];
	logic [15:0] dbRise [GEN_COUNT];
	logic [15:0] dbFall [GEN_COUNT];
	logic [GEN_COUNT-1:0] syncPending;
	logic [5:0] next_outEnable, next_invert, next_faultSelect, next_faultLevel;
	logic [31:0] next_intStatus;
	logic [31:0] next_intMask;
	genCtrl_s next_genCtrl [GEN_COUNT];
	genTiming_s next_shadowTiming [GEN_COUNT];
	logic [15:0] next_dbRise [GEN_COUNT];
	logic [15:0] next_dbFall [GEN_COUNT];
	logic [GEN_COUNT-1:0] next_syncPending;
	logic [31:0] next_prdata;
	logic next_pslverr;

	// Generator views
	logic [GEN_COUNT-1:0][15:0] countView;
	logic [GEN_COUNT-1:0] zeroEvent;
	logic [GEN_COUNT-1:0] applyEvent;
	logic [5:0] genWave;
	logic [5:0] pinWave;
	logic [5:0] next_pinWave;

	// Fault pin synchroniser; stages two and three must agree before a change counts
	logic [2:0] faultSync;
	logic faultActive;
	logic next_faultActive;
	logic firstFaultInterrupt;
	// APB decode
	logic setupPhase;
	logic writeStrobe;
	logic [7:0] genRel;
	logic [1:0] genIdx;
	logic [4:0] genOff;
	logic genHit;

	assign setupPhase = psel & ~penable;
	assign writeStrobe = psel & penable & pwrite;
	assign pready = psel & penable;
	assign genRel = paddr - OFF_GEN_BASE;
	assign genIdx = genRel[GEN_STRIDE_SHIFT+1:GEN_STRIDE_SHIFT];
	assign genOff = genRel[4:0];
	assign genHit = (paddr >= OFF_GEN_BASE) && !genRel[7] && (genIdx < 2'(GEN_COUNT))
		&& (genOff <= GOFF_COUNT) && (genOff[1:0] == 2'h0);
	assign firstFaultInterrupt = intStatus[INT_FAULT_BIT];

	// Read data and error are caught in the setup cycle so the access phase needs no wait
	always_comb begin
		next_prdata = prdata;
		next_pslverr = pslverr;
		if (setupPhase) begin
			next_prdata = 32'h0000_0000;
			next_pslverr = 1'b0;
			if (genHit) begin
				case (genOff)
					GOFF_CTRL: next_prdata = {28'h0000000, genCtrl[genIdx]};
					GOFF_LOAD: next_prdata = {16'h0000, shadowTiming[genIdx].load};
					GOFF_CMP_A: next_prdata = {16'h0000, shadowTiming[genIdx].cmpA};
					GOFF_CMP_B: next_prdata = {16'h0000, shadowTiming[genIdx].cmpB};
					GOFF_DB_RISE: next_prdata = {16'h0000, dbRise[genIdx]};
					GOFF_DB_FALL: next_prdata = {16'h0000, dbFall[genIdx]};
					GOFF_COUNT: next_prdata = {16'h0000, countView[genIdx]};
					default: next_prdata = 32'h0000_0000;
				endcase
			end else begin
				case (paddr)
					OFF_OUT_ENABLE: next_prdata = {26'h0000000, outEnable};
					OFF_INVERT: next_prdata = {26'h0000000, invert};
					OFF_FAULT_SELECT: next_prdata = {26'h0000000, faultSelect};
					OFF_FAULT_LEVEL: next_prdata = {26'h0000000, faultLevel};
					OFF_SYNC: next_prdata = {29'h00000000, syncPending};
					OFF_INT_STATUS: next_prdata = intStatus;
					OFF_INT_MASK: next_prdata = intMask;
					OFF_FAULT_STATE: next_prdata = {31'h00000000, faultActive};
					default: next_pslverr = 1'b1;
				endcase
			end
		end
	end

	// Register writes take effect at the access edge
	always_comb begin
		next_outEnable = outEnable;
		next_invert = invert;
		next_faultSelect = faultSelect;
		next_faultLevel = faultLevel;
		next_intMask = intMask;
		next_genCtrl = genCtrl;
		next_shadowTiming = shadowTiming;
		next_dbRise = dbRise;
		next_dbFall = dbFall;
		// Hardware clears a pending sync once it is applied; a new sync request wins
		next_syncPending = syncPending & ~applyEvent;
		next_intStatus = intStatus;
		if (writeStrobe && !pslverr) begin
			if (genHit) begin
				case (genOff)
					GOFF_CTRL: next_genCtrl[genIdx] = pwdata[3:0];
					GOFF_LOAD: next_shadowTiming[genIdx].load = pwdata[15:0];
					GOFF_CMP_A: next_shadowTiming[genIdx].cmpA = pwdata[15:0];
					GOFF_CMP_B: next_shadowTiming[genIdx].cmpB = pwdata[15:0];
					GOFF_DB_RISE: next_dbRise[genIdx] = pwdata[15:0];
					GOFF_DB_FALL: next_dbFall[genIdx] = pwdata[15:0];
					default: next_intMask = intMask;
				endcase
			end else begin
				case (paddr)
					OFF_OUT_ENABLE: next_outEnable = pwdata[5:0];
					OFF_INVERT: next_invert = pwdata[5:0];
					OFF_FAULT_SELECT: next_faultSelect = pwdata[5:0];
					OFF_FAULT_LEVEL: next_faultLevel = pwdata[5:0];
					OFF_SYNC: next_syncPending = next_syncPending | pwdata[GEN_COUNT-1:0];
					OFF_INT_STATUS: next_intStatus = intStatus & ~pwdata; // [R11]
					OFF_INT_MASK: next_intMask = pwdata;
					default: next_intMask = intMask;
				endcase
			end
		end
		// Events set after the clear, so a same-cycle event is never lost
		next_intStatus[GEN_COUNT-1:0] = next_intStatus[GEN_COUNT-1:0] | zeroEvent;
		next_intStatus[INT_FAULT_BIT] = next_intStatus[INT_FAULT_BIT] | faultActive; // [R11]
		// Unused status and mask bits read as zero
		next_intStatus = next_intStatus & ((32'h1 << INT_FAULT_BIT) | 32'(GEN_COUNT'('1)));
		next_intMask = next_intMask & ((32'h1 << INT_FAULT_BIT) | 32'(GEN_COUNT'('1)));
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			outEnable <= RST_OUTS;
			invert <= RST_OUTS;
			faultSelect <= RST_OUTS;
			faultLevel <= RST_OUTS;
			intStatus <= 32'h0000_0000;
			intMask <= 32'h0000_0000;
			syncPending <= '0;
			for (int i = 0; i < GEN_COUNT; i++) begin
				genCtrl[i] <= '0;
				shadowTiming[i] <= RST_TIMING;
				dbRise[i] <= RST_DB;
				dbFall[i] <= RST_DB;
			end
		end else begin
			prdata <= next_prdata;
			pslverr <= next_pslverr;
			outEnable <= next_outEnable;
			invert <= next_invert;
			faultSelect <= next_faultSelect;
			faultLevel <= next_faultLevel;
			intStatus <= next_intStatus;
			intMask <= next_intMask;
			syncPending <= next_syncPending;
			genCtrl <= next_genCtrl;
			shadowTiming <= next_shadowTiming;
			dbRise <= next_dbRise;
			dbFall <= next_dbFall;
		end
	end

	// One identical generator per pair of outputs [R01]
	for (genvar g = 0; g < GEN_COUNT; g++) begin : genBlock
		logic [15:0] count;
		logic countUp;
		genTiming_s active;
		logic rawA;
		logic rawB;
		logic [15:0] dbCount;
		logic trigger;
		logic [15:0] next_count;
		logic next_countUp;
		genTiming_s next_active;
		logic next_rawA;
		logic next_rawB;
		logic [15:0] next_dbCount;
		genTiming_s useTiming;
		logic pairFirst;
		logic pairSecond;

		// New timing waits for zero, and in sync mode for a sync request too [R14]
		assign applyEvent[g] = (count == 16'h0000) && (!genCtrl[g].syncMode || syncPending[g]);
		assign zeroEvent[g] = genCtrl[g].enable && (count == 16'h0000);
		assign countView[g] = count;
		always_comb begin
			useTiming = applyEvent[g] ? shadowTiming[g] : active;
			next_active = useTiming;
			next_count = count;
			next_countUp = countUp;
			if (genCtrl[g].enable) begin // [R15]
				if (!genCtrl[g].upDown) begin
					next_count = (count == 16'h0000) ? useTiming.load : count - 16'h0001; // [R12]
				end else if (countUp) begin // [R13]
					if (count >= useTiming.load) begin
						next_countUp = 1'b0;
						next_count = (count == 16'h0000) ? 16'h0000 : count - 16'h0001;
					end else begin
						next_count = count + 16'h0001;
					end
				end else if (count == 16'h0000) begin
					next_countUp = 1'b1;
					next_count = (useTiming.load == 16'h0000) ? 16'h0000 : 16'h0001;
				end else begin
					next_count = count - 16'h0001;
				end
			end
			// Comparator A shapes the even output, B the odd one with dead band off [R02] [R07]
			if (genCtrl[g].upDown) begin
				next_rawA = next_count < useTiming.cmpA;
				next_rawB = next_count < useTiming.cmpB;
			end else begin
				next_rawA = next_count >= useTiming.cmpA;
				next_rawB = next_count >= useTiming.cmpB;
			end
			// The timer loads with the edge itself, so the band is exactly the delay
			if (next_rawA != rawA) begin
				next_dbCount = next_rawA ? dbRise[g] : dbFall[g]; // [R09]
			end else if (dbCount != 16'h0000) begin
				next_dbCount = dbCount - 16'h0001;
			end else begin
				next_dbCount = dbCount;
			end
		end

		always_ff @(posedge mclk or negedge reset_n) begin
			if (!reset_n) begin
				count <= 16'h0000;
				countUp <= 1'b1;
				active <= RST_TIMING;
				rawA <= 1'b0;
				rawB <= 1'b0;
				dbCount <= 16'h0000;
				trigger <= 1'b0;
			end else begin
				count <= next_count;
				countUp <= next_countUp;
				active <= next_active;
				rawA <= next_rawA;
				rawB <= next_rawB;
				dbCount <= next_dbCount;
				trigger <= zeroEvent[g];
			end
		end

		// A running timer keeps both outputs low, hence the band [R03]
		assign pairFirst = genCtrl[g].deadBand ? rawA && dbCount == 16'h0000 : rawA; // [R09]
		assign pairSecond = genCtrl[g].deadBand ? !rawA && dbCount == 16'h0000 : rawB; // [R08] [R10]
		assign genWave[2*g] = pairFirst; // [R06]
		assign genWave[2*g+1] = pairSecond; // [R06]
		assign genTrigger[g] = trigger; // [R04]
		assign genIrq[g] = intStatus[g] & intMask[g]; // [R04]
	end

	// Output stage: polarity first, then fault override, then pin enable
	always_comb begin
		next_faultActive = faultActive;
		if (faultSync[1] == faultSync[2]) begin
			next_faultActive = faultSync[2];
		end
		for (int k = 0; k < OUT_COUNT; k++) begin
			if (!outEnable[k]) begin
				next_pinWave[k] = 1'b0; // [R05]
			end else if (faultActive && faultSelect[k]) begin
				next_pinWave[k] = faultLevel[k]; // [R16]
			end else begin
				next_pinWave[k] = genWave[k] ^ invert[k]; // [R05]
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			faultSync <= 3'h0;
			faultActive <= 1'b0;
			pinWave <= RST_OUTS;
		end else begin
			faultSync <= {faultSync[1:0], faultPin};
			faultActive <= next_faultActive;
			pinWave <= next_pinWave;
		end
	end

	assign {wave_out_5, wave_out_4, wave_out_3, wave_out_2, wave_out_1, wave_out_0} = pinWave;
	// Level interrupt; a long fault keeps re-setting its bit until the pin is quiet
	assign irq = |(intStatus & intMask) | (firstFaultInterrupt & intMask[INT_FAULT_BIT]);
endmodule : pwm_unit
`default_nettype wire

// ===== design/pwm_unit_pkg.sv
// Constants, register map and carrier types for the three generator pulse width unit
package pwm_unit_pkg;
	localparam int GEN_COUNT = 3;
	localparam int CNT_WIDTH = 16;
	localparam int OUT_COUNT = 6;
	localparam int ADDR_WIDTH = 8;
	// Global registers
	localparam logic [7:0] OFF_OUT_ENABLE = 8'h00;
	localparam logic [7:0] OFF_INVERT = 8'h04;
	localparam logic [7:0] OFF_FAULT_SELECT = 8'h08;
	localparam logic [7:0] OFF_FAULT_LEVEL = 8'h0C;
	localparam logic [7:0] OFF_SYNC = 8'h10;
	localparam logic [7:0] OFF_INT_STATUS = 8'h14;
	localparam logic [7:0] OFF_INT_MASK = 8'h18;
	localparam logic [7:0] OFF_FAULT_STATE = 8'h1C;
	// Generator windows: base plus index times stride
	localparam logic [7:0] OFF_GEN_BASE = 8'h40;
	localparam int GEN_STRIDE_SHIFT = 5;
	localparam logic [4:0] GOFF_CTRL = 5'h00;
	localparam logic [4:0] GOFF_LOAD = 5'h04;
	localparam logic [4:0] GOFF_CMP_A = 5'h08;
	localparam logic [4:0] GOFF_CMP_B = 5'h0C;
	localparam logic [4:0] GOFF_DB_RISE = 5'h10;
	localparam logic [4:0] GOFF_DB_FALL = 5'h14;
	localparam logic [4:0] GOFF_COUNT = 5'h18;
	// Control field positions
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_UPDOWN_BIT = 1;
	localparam int CTRL_SYNC_BIT = 2;
	localparam int CTRL_DEADBAND_BIT = 3;
	// Interrupt status layout: bits 0..2 generator zero events, bit 16 fault
	localparam int INT_FAULT_BIT = 16;
	// Reset values
	localparam logic [15:0] RST_LOAD = 16'hFFFF;
	localparam logic [15:0] RST_CMP = 16'h0000;
	localparam logic [15:0] RST_DB = 16'h0000;
	localparam logic [5:0] RST_OUTS = 6'h00;

	typedef struct packed {
		logic deadBand;
		logic syncMode;
		logic upDown;
		logic enable;
	} genCtrl_s;

	typedef struct packed {
		logic [15:0] load;
		logic [15:0] cmpA;
		logic [15:0] cmpB;
	} genTiming_s;

	localparam genTiming_s RST_TIMING = '{load: RST_LOAD, cmpA: RST_CMP, cmpB: RST_CMP};
endpackage : pwm_unit_pkg

// ===== verif/power_stage_model.sv
// Power stage model: its fault sensor drives the fault input
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
	input wire logic mclk,
	input wire logic tripReq,
	output logic faultPin
);
	// Sensor is clocked by mclk, in step with the unit; the unit still synchronises it
	initial faultPin = 1'b0;
	always @(posedge mclk) begin
		faultPin <= tripReq;
	end
endmodule : power_stage_model
`default_nettype wire

// ===== verif/pwm_unit_asserts.sv
// Port-level concurrent checks for the pulse width unit
`timescale 1ns/1ps
`default_nettype none
module pwm_unit_asserts (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [2:0] genIrq,
	input wire logic [2:0] genTrigger,
	input wire logic irq
);
	default clocking dc @(posedge mclk); endclocking
	default disable iff (!reset_n);
	chk_ready_access: assert property (psel && penable |-> pready)
		else $error("pready low in access");
	chk_ready_idle: assert property (!penable |-> !pready)
		else $error("pready outside access");
	chk_refused_zero: assert property (pready && pslverr |-> prdata == 32'h0)
		else $error("refused read gave data");
	chk_data_stands: assert property (!(psel && !penable) |=> $stable(prdata) && $stable(pslverr))
		else $error("read answer moved");
	chk_err_after_setup: assert property (pready && pslverr |-> $past(psel && !penable))
		else $error("error without setup");
	chk_irq_from_gen: assert property (genIrq != 3'h0 |-> irq)
		else $error("gen request missing on irq");
	chk_trig_pulse_zero: assert property (genTrigger[0] |=> !genTrigger[0] [*2])
		else $error("gen zero trigger too long");
	chk_trig_pulse_one: assert property (genTrigger[1] |=> !genTrigger[1] ##1 !genTrigger[1])
		else $error("gen one trigger too long");
	chk_trig_pulse_two: assert property ($rose(genTrigger[2]) |=> $fell(genTrigger[2]))
		else $error("gen two trigger too long");
endmodule : pwm_unit_asserts
bind pwm_unit pwm_unit_asserts u_pwm_unit_asserts (.mclk(mclk), .reset_n(reset_n),
	.psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.genIrq(genIrq), .genTrigger(genTrigger), .irq(irq));
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the pulse width unit
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pwm_unit_pkg::*;
	logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, irq, tripReq, faultPin, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed, held;
	logic [2:0] genIrq, genTrigger;
	wire logic [5:0] wv;
	int errTotal, samplesChecked, per, h0, h1, ld[3], ca[3], cb[3];
	pwm_unit u_pwm_unit (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .faultPin(faultPin), .wave_out_0(wv[0]), .wave_out_1(wv[1]),
		.wave_out_2(wv[2]), .wave_out_3(wv[3]), .wave_out_4(wv[4]), .wave_out_5(wv[5]),
		.genIrq(genIrq), .genTrigger(genTrigger), .irq(irq));
	power_stage_model u_power_stage_model (.mclk(mclk), .tripReq(tripReq), .faultPin(faultPin));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [7:0] genAddr(input int g, input logic [4:0] o);
		return OFF_GEN_BASE + 8'(g << GEN_STRIDE_SHIFT) + {3'h0, o};
	endfunction : genAddr
	task automatic wrapUp();
		if (errTotal == 0 && samplesChecked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : wrapUp
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samplesChecked++;
		if (g !== e) begin
			errTotal++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Request held from setup until the edge that sees pready high
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e, input logic ee);
		bus(1'b0, a, 32'h0);
		chk(n, e, rd);
		chk("pslverr", 32'(ee), 32'(er));
	endtask : rdc
	// Third whole period only (the second goes unmeasured): the first may straddle a shadow update
	task automatic meas(input int g);
		int n;
		repeat (2) begin
			n = 0;
			do begin
				@(negedge mclk);
				n++;
			end while (genTrigger[g] !== 1'b1 && n < 300);
			per = 0;
			h0 = 0;
			h1 = 0;
			do begin
				@(negedge mclk);
				per++;
				h0 += int'(wv[2 * g] === 1'b1);
				h1 += int'(wv[2 * g + 1] === 1'b1);
			end while (genTrigger[g] !== 1'b1 && per < 300);
		end
	endtask : meas
	task automatic pcheck(input int g, input int ep, input int e0, input int e1);
		meas(g);
		chk("period", 32'(ep), 32'(per));
		chk("evenHigh", 32'(e0), 32'(h0));
		chk("oddHigh", 32'(e1), 32'(h1));
	endtask : pcheck
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	initial begin
		repeat (40000) @(posedge mclk);
		errTotal++;
		wrapUp();
	end
	initial begin
		{reset_n, psel, penable, pwrite, tripReq} = 5'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		seed = 32'h1608;
		repeat (6) @(posedge mclk);
		reset_n <= 1'b1;
		rdc("load", genAddr(0, GOFF_LOAD), 32'(RST_LOAD), 1'b0);
		rdc("cmpA", genAddr(1, GOFF_CMP_A), 32'(RST_CMP), 1'b0);
		rdc("dbRise", genAddr(2, GOFF_DB_RISE), 32'(RST_DB), 1'b0);
		rdc("unmapped", 8'h30, 32'h0, 1'b1);
		wr(OFF_OUT_ENABLE, 32'h3F);
		for (int g = 0; g < GEN_COUNT; g++) begin
			seed = lfsr(seed);
			ld[g] = 4 + int'(seed[2:0]);
			ca[g] = 1 + int'(seed[5:3]) % (ld[g] - 1);
			cb[g] = 1 + int'(seed[8:6]) % (ld[g] - 1);
			wr(genAddr(g, GOFF_LOAD), 32'(ld[g]));
			wr(genAddr(g, GOFF_CMP_A), 32'(ca[g]));
			wr(genAddr(g, GOFF_CMP_B), 32'(cb[g]));
			wr(genAddr(g, GOFF_CTRL), 32'h1);
			pcheck(g, ld[g] + 1, ld[g] - ca[g] + 1, ld[g] - cb[g] + 1);
			wr(genAddr(g, GOFF_CTRL), 32'h3);
			pcheck(g, 2 * ld[g], 2 * ca[g] - 1, 2 * cb[g] - 1);
			wr(OFF_INVERT, 32'h1 << (2 * g + 1));
			pcheck(g, 2 * ld[g], 2 * ca[g] - 1, 2 * (ld[g] - cb[g]) + 1);
			wr(OFF_INVERT, 32'h0);
		end
		wr(genAddr(0, GOFF_LOAD), 32'hB);
		wr(genAddr(0, GOFF_CMP_A), 32'h5);
		wr(genAddr(0, GOFF_DB_RISE), 32'h2);
		wr(genAddr(0, GOFF_DB_FALL), 32'h3);
		wr(genAddr(0, GOFF_CTRL), 32'h9);
		pcheck(0, 12, 5, 2);
		wr(genAddr(1, GOFF_CTRL), 32'h5);
		wr(genAddr(1, GOFF_LOAD), 32'(ld[1] + 3));
		meas(1);
		chk("heldPeriod", 32'(ld[1] + 1), 32'(per));
		wr(OFF_SYNC, 32'h2);
		meas(1);
		chk("syncPeriod", 32'(ld[1] + 4), 32'(per));
		wr(genAddr(2, GOFF_CTRL), 32'h0);
		bus(1'b0, genAddr(2, GOFF_COUNT), 32'h0);
		held = rd;
		repeat (20) @(posedge mclk);
		rdc("heldCount", genAddr(2, GOFF_COUNT), held, 1'b0);
		wr(OFF_FAULT_SELECT, 32'h3);
		wr(OFF_FAULT_LEVEL, 32'h1);
		wr(OFF_INT_MASK, 32'h10000);
		tripReq <= 1'b1;
		pcheck(0, 12, 12, 0);
		chk("irqFault", 32'h1, 32'(irq));
		rdc("faultState", OFF_FAULT_STATE, 32'h1, 1'b0);
		tripReq <= 1'b0;
		repeat (10) @(posedge mclk);
		rdc("status", OFF_INT_STATUS, 32'h10007, 1'b0);
		wr(OFF_INT_STATUS, 32'h10000);
		rdc("cleared", OFF_INT_STATUS, 32'h7, 1'b0);
		chk("irqQuiet", 32'h0, 32'(irq));
		wr(OFF_INT_MASK, 32'h1);
		@(negedge mclk);
		chk("genIrq", 32'h1, 32'(genIrq));
		chk("irqGen", 32'h1, 32'(irq));
		wr(OFF_INT_STATUS, 32'h4);
		rdc("keptBits", OFF_INT_STATUS, 32'h3, 1'b0);
		wr(OFF_OUT_ENABLE, 32'h0);
		pcheck(0, 12, 0, 0);
		wrapUp();
	end
endmodule : tb
`default_nettype wire
